// File: rtl/s100_chain_select.sv
// interrupt chain, dma grant chain and io port select for the disk card
// How it works
// R1 - card pulls shared open-collector interrupt line low when it wants service.
// R2 - unconnected interrupt chain enable input reads high, giving top priority.
// R3 - interrupt chain output high when this or higher board interrupted.
// R4 - interrupt chain output low when no higher request or already serviced.
// R5 - host hold-acknowledge feeds first board, high only when bus released.
// R6 - dma boards pass bus grant down a chain, one master at once.
// R7 - grant chain output low when no higher dma request or serviced.
// R8 - board with grant input high owns the bus and may run dma.
// R9 - grant chain output high while bus held or higher request pending.
// R10 - top board takes dma acknowledge from local hold-acknowledge, by default.
// R11 - other boards take dma acknowledge from preceding board's chain output.
// R12 - four selectors match a7..a4, default base nibble e.
// R13 - fitted selector reads one, omitted zero, any nibble 0 to f.
// R14 - software may select one of up to six attached drives.
// R15 - card spans sixteen ports, low nibble selects internal function.
// R16 - bus requests only from dma; interrupts from dma, timer or pio.
// R17 - port select only on io cycles matching selectors, gated by strobes.
// R18 - own outstanding bus request holds downstream grant output inactive.
`timescale 1ns/100ps
`include "chain_port_defs.svh"
module s100_chain_select #(
  parameter int DRIVES = `DRIVE_MAX  // number of attachable drives
) (
  input  wire logic       CLK_SYS,            // system clock, 125 MHz
  input  wire logic       SRST,               // synchronous reset, active high
  input  wire logic       IRQ_CHAIN_ENABLE_IN,// chain enable in, pulled high when open
  output logic            IRQ_CHAIN_ENABLE_OUT,// chain enable out to lower board
  input  wire logic       IRQ_DMA,            // interrupt request from dma
  input  wire logic       IRQ_TIMER,          // interrupt request from timer
  input  wire logic       IRQ_PIO,            // interrupt request from pio
  input  wire logic       IRQ_ACK,            // host has serviced our interrupt
  input  wire logic       INT_LINE_IN,        // shared interrupt line level
  output logic            INT_LINE_OUT,       // drive value, always low
  output logic            INT_LINE_OE,        // high while pulling line low
  input  wire logic       HOLD_ACK,           // host hold-acknowledge, high = released
  input  wire logic       DMA_GRANT_CHAIN_IN_N,// grant from preceding board
  output logic            DMA_GRANT_CHAIN_OUT_N,// grant to next board
  input  wire logic       GRANT_SOURCE_LOCAL, // jumper: take grant from hold-ack
  input  wire logic       DMA_BUS_REQ,        // local dma wants the bus
  input  wire logic       DMA_DONE,           // local dma finished its cycles
  output logic            DMA_OWNS_BUS,       // local dma may run
  input  wire logic [3:0] BASE_SEL,           // base nibble jumpers, fitted = one
  input  wire logic [7:0] ADDR,               // bus address low byte
  input  wire logic       IO_RD,              // bus io read strobe
  input  wire logic       IO_WR,              // bus io write strobe
  input  wire logic [7:0] DATA_IN,            // bus write data
  output logic            PORT_SEL,           // card port selected
  output logic            SEL_EXT,            // extended latch port
  output logic            SEL_CMD,            // command/status port
  output logic            SEL_PIO,            // pio ports
  output logic            SEL_DMA,            // dma ports
  output logic            SEL_CTC,            // timer ports
  output logic [`DRIVE_SEL_W-1:0] DRIVE_SEL,  // selected drive number
  output logic            DRIVE_VALID         // a legal drive is selected
);
  typedef struct packed {
    logic                     irq_pend;
    logic                     irq_chain_enable_out;
    chain_port_pkg::grant_state_t gst;
    logic                     gout_n;
    logic                     psel;
    logic [4:0]               sel;
    logic [`DRIVE_SEL_W-1:0]  drive;
    logic                     dvalid;
  } state_t;

  // registered state and its next value
  state_t q, d;
  logic   hit;       // address upper nibble matches the selectors
  logic   grant_in;  // grant as seen through the source jumper
  logic   irq_src;   // any local interrupt source active
  logic   io_cyc;    // an io read or write strobe is up
  chain_port_pkg::port_fn_t fn;

  // value of every state field while reset is held
  localparam state_t RST_STATE = '{
    irq_pend: 1'b0,
    irq_chain_enable_out:      1'b0,
    gst:      chain_port_pkg::GR_IDLE,
    gout_n:   1'b1,  // grant held back from the next board
    psel:     1'b0,
    sel:      5'h00,
    drive:    '0,
    dvalid:   1'b0
  };

  // pending flag: a new request wins over a service acknowledge
  function automatic logic irq_next(input logic pend, input logic src, input logic ack);
    logic v;
    v = pend;
    if (src) begin
      v = 1'b1;
    end else if (ack) begin
      v = 1'b0;
    end
    return v;
  endfunction : irq_next

  // chain enable out: enable seen and this or a higher board interrupting
  function automatic logic chain_out(input logic en, input logic pend, input logic lvl);
    logic upstream;  // shared line low: some board is asking
    upstream = ~lvl;
    return en & (pend | upstream);
  endfunction : chain_out

  // grant goes downstream only when it reached us and nothing local holds it
  function automatic logic grant_pass(input logic granted,
                                      input chain_port_pkg::grant_state_t st,
                                      input logic req);
    return granted && (st == chain_port_pkg::GR_IDLE) && !req;
  endfunction : grant_pass

  // one-hot select lines for a decoded port function
  function automatic logic [4:0] fn_onehot(input chain_port_pkg::port_fn_t f);
    logic [4:0] v;
    v = 5'h00;
    case (f)
      chain_port_pkg::FN_EXT: v[0] = 1'b1;
      chain_port_pkg::FN_CMD: v[1] = 1'b1;
      chain_port_pkg::FN_PIO: v[2] = 1'b1;
      chain_port_pkg::FN_DMA: v[3] = 1'b1;
      chain_port_pkg::FN_CTC: v[4] = 1'b1;
      default: v = 5'h00;
    endcase
    return v;
  endfunction : fn_onehot

  // a drive number is legal below the attached drive count
  function automatic logic drive_ok(input logic [`DRIVE_SEL_W-1:0] num);
    logic [31:0] wide;  // drive number widened for the compare
    wide = 32'(num);
    return (wide < 32'(DRIVES));
  endfunction : drive_ok

  port_decode u_dec (
    .addr     (ADDR),
    .base_sel (BASE_SEL),
    .hit      (hit),
    .fn       (fn)
  );

  // grant source jumper; hold-ack high means released, chain input is active low
  assign grant_in = GRANT_SOURCE_LOCAL ? HOLD_ACK  // see R10 see R5
                                       : ~DMA_GRANT_CHAIN_IN_N;  // see R11
  assign irq_src  = IRQ_DMA | IRQ_TIMER | IRQ_PIO;  // see R16
  assign io_cyc   = IO_RD | IO_WR;

  // next state
  always_comb begin
    d = q;

    // interrupt pending and chain enable out
    d.irq_pend = irq_next(q.irq_pend, irq_src, IRQ_ACK);  // see R1
    d.irq_chain_enable_out = chain_out(IRQ_CHAIN_ENABLE_IN, d.irq_pend, INT_LINE_IN);  // see R2 see R3 see R4

    // local grant tracking
    case (q.gst)
      chain_port_pkg::GR_IDLE: begin
        if (DMA_BUS_REQ) begin
          d.gst = chain_port_pkg::GR_WAIT;
        end
      end
      chain_port_pkg::GR_WAIT: begin
        if (grant_in) begin
          d.gst = chain_port_pkg::GR_OWN;  // see R8
        end
      end
      chain_port_pkg::GR_OWN: begin
        if (DMA_DONE || !grant_in) begin
          d.gst = chain_port_pkg::GR_IDLE;
        end
      end
      default: d.gst = chain_port_pkg::GR_IDLE;
    endcase

    // pass grant down only when released and no local request outstanding
    d.gout_n = ~grant_pass(grant_in, d.gst, DMA_BUS_REQ);  // see R6 see R7 see R9 see R18

    // port select gated by io strobes
    d.psel = hit & io_cyc;  // see R17
    d.sel  = 5'h00;
    if (hit && io_cyc) begin
      d.sel = fn_onehot(fn);  // see R15
    end

    // drive select written through command/status port
    if (hit && IO_WR && fn == chain_port_pkg::FN_CMD) begin
      d.drive  = DATA_IN[`DRIVE_SEL_W-1:0];
      d.dvalid = drive_ok(DATA_IN[`DRIVE_SEL_W-1:0]);  // see R14
    end
  end

  // state register
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  // open-collector interrupt line: drive value always low, enable does the pulling
  assign INT_LINE_OUT          = 1'b0;
  assign INT_LINE_OE           = q.irq_pend;  // see R1
  assign IRQ_CHAIN_ENABLE_OUT  = q.irq_chain_enable_out;

  // dma grant chain and ownership
  assign DMA_GRANT_CHAIN_OUT_N = q.gout_n;
  assign DMA_OWNS_BUS          = (q.gst == chain_port_pkg::GR_OWN);

  // port selects
  assign PORT_SEL              = q.psel;
  assign SEL_EXT               = q.sel[0];
  assign SEL_CMD               = q.sel[1];
  assign SEL_PIO               = q.sel[2];
  assign SEL_DMA               = q.sel[3];
  assign SEL_CTC               = q.sel[4];

  // drive select
  assign DRIVE_SEL             = q.drive;
  assign DRIVE_VALID           = q.dvalid;
endmodule : s100_chain_select

// File: rtl/chain_port_defs.svh
// constants for the priority chain and port select block
`ifndef CHAIN_PORT_DEFS_SVH
`define CHAIN_PORT_DEFS_SVH
`define BASE_NIBBLE_RST   4'hE
`define BASE_HI_BIT       7
`define BASE_LO_BIT       4
`define PORT_FN_W         4
`define DRIVE_MAX         6
`define DRIVE_SEL_W       3
`define EXT_LATCH_FN      4'h0
`define CMD_STAT_FN       4'h1
`define PIO_FN_LO         4'h4
`define PIO_FN_HI         4'h7
`define DMA_FN_LO         4'h8
`define DMA_FN_HI         4'hB
`define CTC_FN_LO         4'hC
`define CTC_FN_HI         4'hF
`endif

// File: rtl/chain_port_pkg.sv
// types for the priority chain and port select block
package chain_port_pkg;
  typedef enum logic [1:0] {
    GR_IDLE = 2'b00,  // no local request
    GR_WAIT = 2'b01,  // request raised, chain not yet granted
    GR_OWN  = 2'b11   // local dma owns the bus
  } grant_state_t;
  typedef enum logic [2:0] {
    FN_NONE = 3'h0,
    FN_EXT  = 3'h1,
    FN_CMD  = 3'h2,
    FN_PIO  = 3'h3,
    FN_DMA  = 3'h4,
    FN_CTC  = 3'h5
  } port_fn_t;
endpackage : chain_port_pkg

// File: rtl/port_decode.sv
// address match and internal function decode for the sixteen io ports
`timescale 1ns/100ps
`include "chain_port_defs.svh"
module port_decode (
  input  wire logic [7:0] addr,      // bus address low byte
  input  wire logic [3:0] base_sel,  // jumper nibble, fitted reads one
  output logic            hit,       // address is in this card's block
  output chain_port_pkg::port_fn_t fn // function chosen by low nibble
);
  logic [3:0] lo;
  assign lo = addr[`PORT_FN_W-1:0];
  // upper nibble match against the selectors
  assign hit = (addr[`BASE_HI_BIT:`BASE_LO_BIT] == base_sel);  // see R12 see R13
  // low nibble picks the internal function
  always_comb begin
    fn = chain_port_pkg::FN_NONE;  // see R15
    if (lo == `EXT_LATCH_FN) begin
      fn = chain_port_pkg::FN_EXT;
    end else if (lo == `CMD_STAT_FN) begin
      fn = chain_port_pkg::FN_CMD;
    end else if (lo >= `PIO_FN_LO && lo <= `PIO_FN_HI) begin
      fn = chain_port_pkg::FN_PIO;
    end else if (lo >= `DMA_FN_LO && lo <= `DMA_FN_HI) begin
      fn = chain_port_pkg::FN_DMA;
    end else if (lo >= `CTC_FN_LO) begin
      fn = chain_port_pkg::FN_CTC;
    end
  end
endmodule : port_decode

// File: tb/host_bus_model.sv
// host side: hold-acknowledge and the pulled-up shared interrupt line
`timescale 1ns/100ps
module host_bus_model #(parameter int LAG = 3) (
  input  wire logic CLK_SYS,          // clock
  input  wire logic bus_req,          // bus request seen by host
  input  wire logic irq_oe,           // card pulls line low
  input  wire logic other_irq,        // other board pulls line low
  output logic      hold_ack = 1'b0,  // bus released
  output logic      int_line          // shared line level
);
  logic [3:0] wait_q = 4'h0;
  // release the bus after a lag, take it back at once
  always @(posedge CLK_SYS) begin
    wait_q <= bus_req ? wait_q + 4'((wait_q < LAG) ? 1 : 0) : 4'h0;
    hold_ack <= bus_req && (wait_q == 4'(LAG));
  end
  assign int_line = ~(irq_oe | other_irq);
endmodule : host_bus_model

// File: tb/chain_select_chk.sv
// concurrent checks on the chain and port select ports
`timescale 1ns/100ps
module chain_select_chk (
  input wire logic       CLK_SYS,               // clock
  input wire logic       SRST,                  // reset
  input wire logic       IRQ_CHAIN_ENABLE_IN,   // chain in
  input wire logic       IRQ_CHAIN_ENABLE_OUT,  // chain out
  input wire logic       IRQ_TIMER,             // timer request
  input wire logic       INT_LINE_OE,           // line pull
  input wire logic       HOLD_ACK,              // bus released
  input wire logic       DMA_GRANT_CHAIN_OUT_N, // grant out
  input wire logic       GRANT_SOURCE_LOCAL,    // jumper
  input wire logic       DMA_BUS_REQ,           // local request
  input wire logic       DMA_OWNS_BUS,          // ownership
  input wire logic [3:0] BASE_SEL,              // base nibble
  input wire logic [7:0] ADDR,                  // address
  input wire logic       IO_RD,                 // read strobe
  input wire logic       PORT_SEL,              // port select
  input wire logic       SEL_CMD                // command port
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  // strobed read aimed at this card
  sequence s_rd_hit; IO_RD && ADDR[7:4] == BASE_SEL; endsequence
  property p_irq_set; IRQ_TIMER |=> INT_LINE_OE; endproperty
  a_irq_set: assert property (p_irq_set) else $error("line not pulled");
  property p_chain_off; !IRQ_CHAIN_ENABLE_IN |=> !IRQ_CHAIN_ENABLE_OUT; endproperty
  a_chain_off: assert property (p_chain_off) else $error("chain out high");
  property p_chain_on; IRQ_CHAIN_ENABLE_IN && INT_LINE_OE |=> IRQ_CHAIN_ENABLE_OUT; endproperty
  a_chain_on: assert property (p_chain_on) else $error("chain out low");
  property p_req_hold; DMA_BUS_REQ |=> DMA_GRANT_CHAIN_OUT_N; endproperty
  a_req_hold: assert property (p_req_hold) else $error("grant passed on");
  property p_no_rel; GRANT_SOURCE_LOCAL && !HOLD_ACK |=> DMA_GRANT_CHAIN_OUT_N; endproperty
  a_no_rel: assert property (p_no_rel) else $error("grant without release");
  property p_own_loss; GRANT_SOURCE_LOCAL && !HOLD_ACK |=> !DMA_OWNS_BUS; endproperty
  a_own_loss: assert property (p_own_loss) else $error("owns without grant");
  property p_sel_miss; ADDR[7:4] != BASE_SEL |=> !PORT_SEL; endproperty
  a_sel_miss: assert property (p_sel_miss) else $error("select on miss");
  property p_sel_cmd; s_rd_hit ##0 ADDR[3:0] == 4'h1 |=> PORT_SEL && SEL_CMD; endproperty
  a_sel_cmd: assert property (p_sel_cmd) else $error("command port missed");
endmodule : chain_select_chk
bind s100_chain_select chain_select_chk u_chk (.CLK_SYS(CLK_SYS), .SRST(SRST),
  .IRQ_CHAIN_ENABLE_IN(IRQ_CHAIN_ENABLE_IN), .IRQ_CHAIN_ENABLE_OUT(IRQ_CHAIN_ENABLE_OUT),
  .IRQ_TIMER(IRQ_TIMER), .INT_LINE_OE(INT_LINE_OE), .HOLD_ACK(HOLD_ACK),
  .DMA_GRANT_CHAIN_OUT_N(DMA_GRANT_CHAIN_OUT_N), .GRANT_SOURCE_LOCAL(GRANT_SOURCE_LOCAL),
  .DMA_BUS_REQ(DMA_BUS_REQ), .DMA_OWNS_BUS(DMA_OWNS_BUS), .BASE_SEL(BASE_SEL),
  .ADDR(ADDR), .IO_RD(IO_RD), .PORT_SEL(PORT_SEL), .SEL_CMD(SEL_CMD));

// File: tb/test_s100_chain_select.sv
// self-checking bench for the chain and port select block
`timescale 1ns/100ps
module test_s100_chain_select;
  logic clk_sys = 1'b0, srst = 1'b1, irq_chain_enable_in = 1'b1, irq_dma = 1'b0, irq_tmr = 1'b0;
  logic irq_pio = 1'b0, irq_ack = 1'b0, other_irq = 1'b0, gin_n = 1'b1, src_local = 1'b1;
  logic bus_req = 1'b0, dma_done = 1'b0, io_rd = 1'b0, io_wr = 1'b0;
  logic [3:0] base_sel = 4'hE;
  logic [7:0] addr = 8'h00, data_in = 8'h00;
  logic irq_chain_enable_out, int_line, int_out, int_oe, hold_ack, gout_n, owns, port_sel, drive_valid;
  logic sel_ext, sel_cmd, sel_pio, sel_dma, sel_ctc;
  logic [2:0] drive_sel;
  int error_cnt = 0, cmp_count = 0, cyc = 0, n;
  s100_chain_select u_dut (.CLK_SYS(clk_sys), .SRST(srst), .IRQ_CHAIN_ENABLE_IN(irq_chain_enable_in),
    .IRQ_CHAIN_ENABLE_OUT(irq_chain_enable_out), .IRQ_DMA(irq_dma), .IRQ_TIMER(irq_tmr), .IRQ_PIO(irq_pio),
    .IRQ_ACK(irq_ack), .INT_LINE_IN(int_line), .INT_LINE_OUT(int_out), .INT_LINE_OE(int_oe),
    .HOLD_ACK(hold_ack), .DMA_GRANT_CHAIN_IN_N(gin_n), .DMA_GRANT_CHAIN_OUT_N(gout_n),
    .GRANT_SOURCE_LOCAL(src_local), .DMA_BUS_REQ(bus_req), .DMA_DONE(dma_done),
    .DMA_OWNS_BUS(owns), .BASE_SEL(base_sel), .ADDR(addr), .IO_RD(io_rd), .IO_WR(io_wr),
    .DATA_IN(data_in), .PORT_SEL(port_sel), .SEL_EXT(sel_ext), .SEL_CMD(sel_cmd),
    .SEL_PIO(sel_pio), .SEL_DMA(sel_dma), .SEL_CTC(sel_ctc), .DRIVE_SEL(drive_sel),
    .DRIVE_VALID(drive_valid));
  host_bus_model u_host (.CLK_SYS(clk_sys), .bus_req(bus_req), .irq_oe(int_oe),
    .other_irq(other_irq), .hold_ack(hold_ack), .int_line(int_line));
  // compare one result and count it
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  // every low nibble against a hit, a miss and a moved base
  task automatic t_ports();
    logic h;
    for (int i = 0; i < 48; i++) begin
      h = (i < 16) || (i >= 32);
      @(posedge clk_sys);
      addr <= {(i < 16) ? 4'hE : 4'h3, 4'(i)};
      base_sel <= (i < 32) ? 4'hE : 4'h3;
      io_rd <= 1'b1;
      @(posedge clk_sys); #1;
      chk("sel", {3'h0, h, h && i % 16 == 0, h && i % 16 == 1, h && i % 16 / 4 == 1,
        h && i % 16 / 4 == 2}, {3'h0, port_sel, sel_ext, sel_cmd, sel_pio, sel_dma});
      chk("ctc", 8'(h && i % 16 >= 12), 8'(sel_ctc));
    end
    @(posedge clk_sys);
    io_rd <= 1'b0;
    base_sel <= 4'hE;
  endtask : t_ports
  // drive number on both sides of the limit
  task automatic t_drive();
    for (int d = 5; d < 7; d++) begin
      @(posedge clk_sys);
      addr <= 8'hE1; io_wr <= 1'b1; data_in <= 8'(d);
      @(posedge clk_sys); #1;
      chk("drv", 8'(d < 6), 8'(drive_valid));
      chk("drv_wr", 8'(d), 8'(drive_sel));
      chk("wsel", 8'h3, {6'h0, port_sel, sel_cmd});
    end
    chk("drv_num", 8'h6, 8'(drive_sel));
    @(posedge clk_sys);
    io_wr <= 1'b0;
  endtask : t_drive
  // each source raises the line, service clears it, chain follows upstream
  task automatic t_irq();
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_sys); {irq_pio, irq_tmr, irq_dma} <= 3'(1 << k);
      @(posedge clk_sys); {irq_pio, irq_tmr, irq_dma} <= 3'h0;
      repeat (2) @(posedge clk_sys); #1;
      chk("irq", 8'h3, {5'h0, int_out, int_oe, irq_chain_enable_out});
      @(posedge clk_sys); irq_ack <= 1'b1;
      @(posedge clk_sys); irq_ack <= 1'b0;
      repeat (2) @(posedge clk_sys); #1;
      chk("irq_done", 8'h0, {5'h0, int_out, int_oe, irq_chain_enable_out});
    end
    @(posedge clk_sys); other_irq <= 1'b1; irq_chain_enable_in <= 1'b0;
    repeat (3) @(posedge clk_sys); #1;
    chk("ieo_blk", 8'h0, 8'(irq_chain_enable_out));
    @(posedge clk_sys); irq_chain_enable_in <= 1'b1;
    repeat (3) @(posedge clk_sys); #1;
    chk("ieo_up", 8'h1, 8'(irq_chain_enable_out));
    @(posedge clk_sys);
    other_irq <= 1'b0;
  endtask : t_irq
  // wait a bounded time for ownership
  task automatic wait_own();
    n = 0;
    while (owns !== 1'b1 && n < 20) begin @(posedge clk_sys); #1; n++; end
    chk("owns", 8'h1, 8'(owns));
  endtask : wait_own
  // local then chained grant source, release and pass-through
  task automatic t_dma();
    @(posedge clk_sys); bus_req <= 1'b1;
    @(posedge clk_sys); #1;
    chk("hold", 8'h1, 8'(gout_n));
    wait_own();
    @(posedge clk_sys); dma_done <= 1'b1; bus_req <= 1'b0;
    @(posedge clk_sys); dma_done <= 1'b0;
    repeat (3) @(posedge clk_sys); #1;
    chk("idle", 8'h1, {7'h0, gout_n & ~owns});
    @(posedge clk_sys); src_local <= 1'b0; bus_req <= 1'b1;
    repeat (8) @(posedge clk_sys); #1;
    chk("no_up", 8'h0, 8'(owns));
    @(posedge clk_sys); gin_n <= 1'b0;
    wait_own();
    @(posedge clk_sys); dma_done <= 1'b1; bus_req <= 1'b0;
    @(posedge clk_sys); dma_done <= 1'b0;
    repeat (3) @(posedge clk_sys); #1;
    chk("pass", 8'h0, 8'(gout_n));
    @(posedge clk_sys); bus_req <= 1'b1;
    @(posedge clk_sys); #1;
    chk("hold_dn", 8'h1, 8'(gout_n));
    @(posedge clk_sys); bus_req <= 1'b0;
  endtask : t_dma
  // print counts and verdict, then end the run
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  // clock and hang guard
  initial forever #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin error_cnt++; stop_test(); end
  end
  // main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    t_ports(); t_drive(); t_irq(); t_dma();
    stop_test();
  end
endmodule : test_s100_chain_select
